//--- src/cfg_loader.sv
// Purpose: Holds and decodes the two configuration words and user IDs
// Assumes: Programmer port is only honoured while prog_mode is high
// Notes: Settings latch at reset release, follow stored words while prog_mode is high, and stay fixed otherwise
`timescale 1ns/1ps
`include "cfg_regs.svh"

// Function
// RULE_01: RC clock-out mode drives osc/4 out
// RULE_02: RC I/O mode frees second pin
// RULE_03: Config words at 2007h/2008h, programming only
// RULE_04: Bit 13 set disables debugger pins
// RULE_05: Bit 12 picks 500 kHz or 16 MHz
// RULE_06: Bit 10 picks 2.5 V or 1.9 V
// RULE_07: Brown-out field: 0x off, 10 run, 11 on
// RULE_08: Brown-out never enables power-up timer
// RULE_09: Bit 6 cleared enables code protection
// RULE_10: Protection on-to-off erases program memory
// RULE_11: Bit 5 selects reset pin or input
// RULE_12: Reset held stops internal/RC oscillator
// RULE_13: Bit 4 low enables power-up timer
// RULE_14: Bit 3 set enables watchdog
// RULE_15: Oscillator select field decodes eight modes
// RULE_16: Regulator cap pin select, ignored on low-voltage
// RULE_17: Unimplemented config bits read as one
// RULE_18: User IDs 2000h-2003h only in program mode
// RULE_19: Unprotected memory readable for verification
// RULE_20: Internal clock-out mode drives freq/4 out
// RULE_21: Crystal modes wait 1024 cycles, external none
// RULE_22: Settings latched at reset, constant after; code also reloads them while prog_mode is high
module cfg_loader
    import cfg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Device variant strap
    input wire logic low_voltage_part,
    // Programmer port
    input wire logic prog_mode,
    input wire logic prog_wr,
    input wire logic prog_rd,
    input wire logic [13:0] prog_addr,
    input wire logic [15:0] prog_wdata,
    output logic [15:0] prog_rdata,
    output logic prog_rvalid,
    // Program memory erase and read-out
    output logic mem_erase,
    output logic mem_read_allow,
    // Pins and clock sources
    input wire logic master_reset_n,
    input wire logic osc_pin_in,
    input wire logic sleep_active,
    output logic osc_pin_out,
    output logic osc_pin_out_oe,
    output logic osc_pin_out_gpio,
    output logic osc_pin_in_gpio,
    output logic internal_osc_off,
    // Decoded settings
    output logic debugger_pins_gpio,
    output logic int_osc_multiplier_on,
    output logic brownout_level_sel,
    output logic brownout_active,
    output logic powerup_timer_on,
    output logic watchdog_enable,
    output logic reset_pin_function,
    output logic internal_reset_n,
    output logic code_protect_on,
    output logic [1:0] regulator_cap_pin_sel,
    output logic [2:0] regulator_cap_pin,
    output cfg_osc_e osc_mode,
    output logic startup_release
);
    // Stored words, erased state is all ones
    logic [15:0] word_one;
    logic [15:0] word_two;
    logic [15:0] next_word_one;
    logic [15:0] next_word_two;
    logic [13:0] user_id [0:3]; // User identification locations
    logic [13:0] next_user_id [0:3];
    // Latched copies that drive the decode
    logic [15:0] live_one;
    logic [15:0] live_two;
    logic [15:0] next_live_one;
    logic [15:0] next_live_two;
    logic loaded;
    logic next_loaded;
    // Read path
    logic [15:0] next_rdata;
    logic next_rvalid;
    logic next_erase;
    // Pin synchroniser for the reset pin
    logic [2:0] rpin_sync;
    logic rpin_level;
    logic next_rpin_level;
    // Oscillator pin synchroniser and edge
    logic [2:0] osc_sync;
    logic osc_prev;
    logic [1:0] div_cnt;
    logic [1:0] next_div_cnt;
    logic div_out;
    logic next_div_out;
    logic [10:0] start_cnt;
    logic [10:0] next_start_cnt;
    logic osc_edge;
    logic id_hit;
    logic [1:0] id_idx;

    assign id_hit = prog_addr >= `CFG_ADDR_ID_FIRST &&
                    prog_addr <= `CFG_ADDR_ID_LAST;
    assign id_idx = prog_addr[1:0];
    assign osc_edge = (osc_sync[2] == osc_sync[1]) &&
                      osc_sync[1] && !osc_prev;

    // Programmer writes and reads of the config space
    always_comb begin
        next_word_one = word_one;
        next_word_two = word_two;
        next_user_id = user_id;
        next_rdata = prog_rdata;
        next_rvalid = 1'b0;
        next_erase = 1'b0;
        if (prog_mode && prog_wr) begin // RULE_03 RULE_18
            if (prog_addr == `CFG_ADDR_WORD_ONE) begin
                // Protection on-to-off wipes program memory
                if (!word_one[`CFG_BIT_PROT_N] &&
                    prog_wdata[`CFG_BIT_PROT_N]) begin
                    next_erase = 1'b1; // RULE_10
                end
                next_word_one = prog_wdata | ~`CFG_MASK_ONE; // RULE_17
            end else if (prog_addr == `CFG_ADDR_WORD_TWO) begin
                next_word_two = prog_wdata | ~`CFG_MASK_TWO; // RULE_17
            end else if (id_hit) begin
                next_user_id[id_idx] = prog_wdata[13:0];
            end
        end else if (prog_mode && prog_rd) begin
            next_rvalid = 1'b1;
            if (prog_addr == `CFG_ADDR_WORD_ONE) begin
                next_rdata = word_one;
            end else if (prog_addr == `CFG_ADDR_WORD_TWO) begin
                next_rdata = word_two;
            end else if (id_hit) begin
                next_rdata = {2'b00, user_id[id_idx]};
            end else begin
                next_rdata = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word_one <= `CFG_ERASED;
            word_two <= `CFG_ERASED;
            user_id <= '{default: 14'h3FFF};
            prog_rdata <= 16'h0000;
            prog_rvalid <= 1'b0;
            mem_erase <= 1'b0;
        end else begin
            word_one <= next_word_one;
            word_two <= next_word_two;
            user_id <= next_user_id;
            prog_rdata <= next_rdata;
            prog_rvalid <= next_rvalid;
            mem_erase <= next_erase;
        end
    end

    // Latch settings on the first edge out of reset and in program mode
    always_comb begin
        next_live_one = live_one;
        next_live_two = live_two;
        next_loaded = 1'b1;
        if (!loaded || prog_mode) begin // RULE_22
            next_live_one = word_one;
            next_live_two = word_two;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            live_one <= `CFG_ERASED;
            live_two <= `CFG_ERASED;
            loaded <= 1'b0;
        end else begin
            live_one <= next_live_one;
            live_two <= next_live_two;
            loaded <= next_loaded;
        end
    end

    // Field decode
    assign osc_mode = cfg_osc_e'(live_one[`CFG_OSC_HI:`CFG_OSC_LO]); // RULE_15
    assign debugger_pins_gpio = live_one[`CFG_BIT_DEBUG_N]; // RULE_04
    assign int_osc_multiplier_on = live_one[`CFG_BIT_PLL]; // RULE_05
    assign brownout_level_sel = live_one[`CFG_BIT_BOR_LEVEL]; // RULE_06
    assign brownout_active = live_one[`CFG_BIT_BOR_HI] &&
        (live_one[`CFG_BIT_BOR_LO] || !sleep_active); // RULE_07
    assign powerup_timer_on = !live_one[`CFG_BIT_PWRT_N]; // RULE_08 RULE_13
    assign watchdog_enable = live_one[`CFG_BIT_WDT]; // RULE_14
    assign code_protect_on = !live_one[`CFG_BIT_PROT_N]; // RULE_09
    assign mem_read_allow = prog_mode && !code_protect_on; // RULE_19
    assign reset_pin_function = live_one[`CFG_BIT_RESET_PIN];
    assign internal_reset_n = reset_pin_function ? rpin_level : 1'b1; // RULE_11
    assign regulator_cap_pin_sel =
        live_two[`CFG_VCAP_HI:`CFG_VCAP_LO];

    // One-hot cap pin: bit0 pin 0, bit1 pin 5, bit2 pin 6
    always_comb begin
        regulator_cap_pin = 3'h0;
        if (!low_voltage_part) begin // RULE_16
            unique case (regulator_cap_pin_sel)
                2'h0: regulator_cap_pin = 3'h1;
                2'h1: regulator_cap_pin = 3'h2;
                2'h2: regulator_cap_pin = 3'h4;
                2'h3: regulator_cap_pin = 3'h0;
            endcase
        end
    end

    // Oscillator pin roles
    always_comb begin
        osc_pin_out_gpio = 1'b0;
        osc_pin_in_gpio = 1'b0;
        osc_pin_out_oe = 1'b0;
        unique case (osc_mode)
            resistor_cap_osc_mode: osc_pin_out_oe = 1'b1; // RULE_01
            resistor_cap_osc_io_mode: osc_pin_out_gpio = 1'b1; // RULE_02
            internal_osc_clock_out_mode: begin
                osc_pin_out_oe = 1'b1; // RULE_20
                osc_pin_in_gpio = 1'b1;
            end
            internal_osc_both_io_mode: begin
                osc_pin_out_gpio = 1'b1;
                osc_pin_in_gpio = 1'b1;
            end
            ext_logic_clock_mode: osc_pin_out_gpio = 1'b1;
            // Crystal modes use both pins
            low_power_crystal_mode, medium_crystal_mode,
            high_speed_crystal_mode: ;
        endcase
    end
    assign osc_pin_out = osc_pin_out_oe & div_out;

    // Reset pin held stops internal and RC oscillators
    assign internal_osc_off = reset_pin_function && !rpin_level &&
        (osc_mode inside {resistor_cap_osc_mode, resistor_cap_osc_io_mode,
                          internal_osc_clock_out_mode,
                          internal_osc_both_io_mode}); // RULE_12

    // Reset pin filter: change counts when stages two and three agree
    always_comb begin
        next_rpin_level = rpin_level;
        if (rpin_sync[2] == rpin_sync[1]) begin
            next_rpin_level = rpin_sync[2];
        end
    end

    // Divide-by-four of oscillator edges, and start-up count
    always_comb begin
        next_div_cnt = div_cnt;
        next_div_out = div_out;
        next_start_cnt = start_cnt;
        if (osc_edge) begin
            next_div_cnt = div_cnt + 2'd1;
            if (div_cnt[0]) begin
                next_div_out = !div_out; // RULE_01 RULE_20
            end
            if (start_cnt != 11'(`CFG_STARTUP_CYCLES)) begin
                next_start_cnt = start_cnt + 11'd1; // RULE_21
            end
        end
        if (osc_mode == ext_logic_clock_mode || osc_mode > 3'd3) begin
            next_start_cnt = 11'(`CFG_STARTUP_CYCLES);
        end
        if (sleep_active) begin
            next_start_cnt = 11'd0;
        end
    end
    assign startup_release = start_cnt == 11'(`CFG_STARTUP_CYCLES);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rpin_sync <= 3'h7;
            rpin_level <= 1'b1;
            osc_sync <= 3'h0;
            osc_prev <= 1'b0;
            div_cnt <= 2'h0;
            div_out <= 1'b0;
            start_cnt <= 11'd0;
        end else begin
            rpin_sync <= {rpin_sync[1:0], master_reset_n};
            rpin_level <= next_rpin_level;
            osc_sync <= {osc_sync[1:0], osc_pin_in};
            osc_prev <= (osc_sync[2] == osc_sync[1]) ? osc_sync[1] : osc_prev;
            div_cnt <= next_div_cnt;
            div_out <= next_div_out;
            start_cnt <= next_start_cnt;
        end
    end

    // Checks
    sequence s_prot_drop;
        prog_mode && prog_wr && prog_addr == `CFG_ADDR_WORD_ONE &&
        !word_one[`CFG_BIT_PROT_N] && prog_wdata[`CFG_BIT_PROT_N];
    endsequence
    property p_erase;
        @(posedge clk) disable iff (rst) s_prot_drop |=> mem_erase;
    endproperty
    a_erase: assert property (p_erase) else $error("no erase"); // RULE_10
    property p_nowrite;
        @(posedge clk) disable iff (rst)
        !prog_mode |=> $stable(word_one) && $stable(word_two);
    endproperty
    a_nowrite: assert property (p_nowrite) else $error("cfg moved"); // RULE_03
    property p_ones;
        @(posedge clk) disable iff (rst)
        (word_one | `CFG_MASK_ONE) == 16'hFFFF &&
        (word_two | `CFG_MASK_TWO) == 16'hFFFF;
    endproperty
    a_ones: assert property (p_ones) else $error("unimpl bit zero"); // RULE_17
    property p_steady;
        @(posedge clk) disable iff (rst)
        loaded && !prog_mode |=> $stable(live_one);
    endproperty
    a_steady: assert property (p_steady) else $error("live moved"); // RULE_22
    property p_pwrt;
        @(posedge clk) disable iff (rst)
        powerup_timer_on == !live_one[`CFG_BIT_PWRT_N];
    endproperty
    a_pwrt: assert property (p_pwrt) else $error("pwrt wrong"); // RULE_13
    // Brown-out field changes must never move the power-up timer
    property p_pwrt_bor;
        @(posedge clk) disable iff (rst)
        $changed(live_one[`CFG_BIT_BOR_HI:`CFG_BIT_BOR_LO]) &&
        $stable(live_one[`CFG_BIT_PWRT_N]) |-> $stable(powerup_timer_on);
    endproperty
    a_pwrt_bor: assert property (p_pwrt_bor) // RULE_08
        else $error("pwrt follows bor");
    property p_bor;
        @(posedge clk) disable iff (rst)
        !live_one[`CFG_BIT_BOR_HI] |-> !brownout_active;
    endproperty
    a_bor: assert property (p_bor) else $error("bor on"); // RULE_07
    property p_rpin;
        @(posedge clk) disable iff (rst)
        !reset_pin_function |-> internal_reset_n;
    endproperty
    a_rpin: assert property (p_rpin) else $error("reset active"); // RULE_11
    property p_id;
        @(posedge clk) disable iff (rst)
        !prog_mode |=> !prog_rvalid && $stable(user_id[0]);
    endproperty
    a_id: assert property (p_id) else $error("id reached"); // RULE_18
    property p_ext;
        @(posedge clk) disable iff (rst)
        osc_mode == ext_logic_clock_mode && !sleep_active |=> startup_release;
    endproperty
    a_ext: assert property (p_ext) else $error("startup held"); // RULE_21
endmodule

//--- src/cfg_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Word addresses in program space, 14-bit words held in 16 bits
// Notes: Included by the loader module
`ifndef CFG_REGS_SVH
`define CFG_REGS_SVH
// Program-space addresses
`define CFG_ADDR_WORD_ONE 14'h2007
`define CFG_ADDR_WORD_TWO 14'h2008
`define CFG_ADDR_ID_FIRST 14'h2000
`define CFG_ADDR_ID_LAST 14'h2003
// Word one fields
`define CFG_BIT_DEBUG_N 13
`define CFG_BIT_PLL 12
`define CFG_BIT_BOR_LEVEL 10
`define CFG_BIT_BOR_HI 9
`define CFG_BIT_BOR_LO 8
`define CFG_BIT_PROT_N 6
`define CFG_BIT_RESET_PIN 5
`define CFG_BIT_PWRT_N 4
`define CFG_BIT_WDT 3
`define CFG_OSC_HI 2
`define CFG_OSC_LO 0
// Word two fields
`define CFG_VCAP_HI 5
`define CFG_VCAP_LO 4
// Implemented-bit masks; others read as one
`define CFG_MASK_ONE 16'h377F
`define CFG_MASK_TWO 16'h0030
`define CFG_ERASED 16'hFFFF
// Internal oscillator register reset values
`define CFG_FREQ_SEL_RESET 2'h2
`define CFG_TRIM_RESET 6'h00
// Clock-out divide and start-up timer counts
`define CFG_OUT_DIV 4
`define CFG_STARTUP_CYCLES 1024
`endif

//--- src/cfg_pkg.sv
// Purpose: Types shared by the configuration loader
// Assumes: Codes follow the three-bit oscillator select field
// Notes: Numbers live in cfg_regs.svh
package cfg_pkg;
    // Oscillator select decode, in field order 000..111
    typedef enum logic [2:0] {
        low_power_crystal_mode,
        medium_crystal_mode,
        high_speed_crystal_mode,
        ext_logic_clock_mode,
        internal_osc_both_io_mode,
        internal_osc_clock_out_mode,
        resistor_cap_osc_io_mode,
        resistor_cap_osc_mode
    } cfg_osc_e;
    // Program/verify sequencer states
    typedef enum logic [1:0] {
        cfg_idle,
        cfg_erase,
        cfg_done
    } cfg_prog_e;
endpackage

//--- tb/cfg_prog_model.sv
// Purpose: Programmer model for the program/verify port
// Assumes: Each task launches its request just after a rising edge
// Notes: Released address and data are inverted so stale values never match
`timescale 1ns/1ps
module cfg_prog_model (
    // Clock
    input wire logic clk,
    // Programmer port
    output logic prog_mode,
    output logic prog_wr,
    output logic prog_rd,
    output logic [13:0] prog_addr,
    output logic [15:0] prog_wdata,
    input wire logic [15:0] prog_rdata,
    input wire logic prog_rvalid
);
    // Idle programmer, outside program/verify mode
    initial begin
        prog_mode = 1'b0;
        prog_wr = 1'b0;
        prog_rd = 1'b0;
        prog_addr = 14'h0000;
        prog_wdata = 16'h0000;
    end
    // Enter or leave program/verify mode
    task automatic set_mode(input logic m);
        @(posedge clk);
        prog_mode <= m;
    endtask
    // One word written, held over its sampling edge, then released
    task automatic wr_word(input logic [13:0] a, input logic [15:0] d);
        @(posedge clk);
        prog_wr <= 1'b1;
        prog_addr <= a;
        prog_wdata <= d;
        @(posedge clk);
        prog_wr <= 1'b0;
        prog_addr <= ~a;
        prog_wdata <= ~d;
        @(posedge clk);
        #1;
    endtask
    // One word read; valid and data taken just after the sampling edge
    task automatic rd_word(input logic [13:0] a, output logic [15:0] d,
                           output logic v);
        @(posedge clk);
        prog_rd <= 1'b1;
        prog_addr <= a;
        @(posedge clk);
        prog_rd <= 1'b0;
        prog_addr <= ~a;
        #1;
        v = prog_rvalid;
        d = prog_rdata;
    endtask
endmodule

//--- tb/config_word_clock_select_tb.sv
// Purpose: Self-checking bench for the configuration loader
// Assumes: 10 MHz clock, settings follow stored words in program mode
// Notes: Oscillator pin toggles every two clocks to feed divider and timer
`timescale 1ns/1ps
module config_word_clock_select_tb
    import cfg_pkg::*;
();
    // Design inputs driven by the bench
    logic clk, rst, low_voltage_part, master_reset_n, osc_pin_in, sleep_active;
    // Programmer port and design outputs
    logic prog_mode, prog_wr, prog_rd, prog_rvalid, mem_erase, mem_read_allow;
    logic [13:0] prog_addr;
    logic [15:0] prog_wdata, prog_rdata;
    logic osc_pin_out, osc_pin_out_oe, osc_pin_out_gpio, osc_pin_in_gpio;
    logic internal_osc_off, debugger_pins_gpio, int_osc_multiplier_on;
    logic brownout_level_sel, brownout_active, powerup_timer_on;
    logic watchdog_enable, reset_pin_function, internal_reset_n;
    logic code_protect_on, startup_release;
    logic [1:0] regulator_cap_pin_sel;
    logic [2:0] regulator_cap_pin;
    cfg_osc_e osc_mode;
    int mismatches, checks, erases, out_rises;
    // Expected {out enable, out pin free, in pin free} per oscillator code
    localparam logic [2:0] pin_tab [8] = '{3'b000, 3'b000, 3'b000, 3'b010,
        3'b011, 3'b101, 3'b010, 3'b100};

    cfg_loader cfg_loader_i (.clk, .rst, .low_voltage_part, .prog_mode,
        .prog_wr, .prog_rd, .prog_addr, .prog_wdata, .prog_rdata,
        .prog_rvalid, .mem_erase, .mem_read_allow, .master_reset_n,
        .osc_pin_in, .sleep_active, .osc_pin_out, .osc_pin_out_oe,
        .osc_pin_out_gpio, .osc_pin_in_gpio, .internal_osc_off,
        .debugger_pins_gpio, .int_osc_multiplier_on, .brownout_level_sel,
        .brownout_active, .powerup_timer_on, .watchdog_enable,
        .reset_pin_function, .internal_reset_n, .code_protect_on,
        .regulator_cap_pin_sel, .regulator_cap_pin, .osc_mode,
        .startup_release);
    cfg_prog_model cfg_prog_model_i (.clk, .prog_mode, .prog_wr, .prog_rd,
        .prog_addr, .prog_wdata, .prog_rdata, .prog_rvalid);

    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Count erase pulses and divided clock rises
    always @(posedge clk) begin
        if (mem_erase === 1'b1) erases <= erases + 1;
    end
    always @(posedge osc_pin_out) out_rises <= out_rises + 1;

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Single value comparison
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic w(input logic [13:0] a, input logic [15:0] d);
        cfg_prog_model_i.wr_word(a, d);
    endtask
    // Read one word, expecting an answer only when v is set
    task automatic rd(input logic [13:0] a, input logic [15:0] e,
                      input logic v);
        logic [15:0] d;
        logic ok;
        cfg_prog_model_i.rd_word(a, d, ok);
        chk(16'(ok), 16'(v));
        if (v) chk(d, e);
    endtask
    // Pin toggles: two clocks high, two low
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk);
            osc_pin_in <= 1'b1;
            repeat (2) @(posedge clk);
            osc_pin_in <= 1'b0;
            @(posedge clk);
        end
        #1;
    endtask
    // Refused access outside program mode, reset values, IDs, unmapped
    task automatic t_access();
        w(14'h2007, 16'h0000);
        w(14'h2000, 16'h0000);
        rd(14'h2007, 16'h0000, 1'b0);
        rd(14'h2000, 16'h0000, 1'b0);
        cfg_prog_model_i.set_mode(1'b1);
        rd(14'h2007, 16'hFFFF, 1'b1);
        rd(14'h2008, 16'hFFFF, 1'b1);
        rd(14'h2000, 16'h3FFF, 1'b1);
        rd(14'h2009, 16'h0000, 1'b1);
        w(14'h2001, 16'hFABC);
        rd(14'h2001, 16'h3ABC, 1'b1);
    endtask
    // All word one bits cleared, then set: decodes and erase on unprotect
    task automatic t_word_one();
        erases = 0;
        w(14'h2007, 16'h0000);
        rd(14'h2007, 16'hC880, 1'b1);
        chk({debugger_pins_gpio, int_osc_multiplier_on, brownout_level_sel,
            powerup_timer_on}, 16'h0001);
        chk({watchdog_enable, reset_pin_function, code_protect_on,
            mem_read_allow}, 16'h0002);
        chk(16'(erases), 16'h0000);
        w(14'h2007, 16'hFFFF);
        rd(14'h2007, 16'hFFFF, 1'b1);
        chk({debugger_pins_gpio, int_osc_multiplier_on, brownout_level_sel,
            powerup_timer_on}, 16'h000E);
        chk({watchdog_enable, reset_pin_function, code_protect_on,
            mem_read_allow}, 16'h000D);
        w(14'h2007, 16'hFFFF);
        step(2);
        chk(16'(erases), 16'h0001);
    endtask
    // Every oscillator code and its pin functions
    task automatic t_osc_modes();
        for (int c = 0; c < 8; c++) begin
            w(14'h2007, 16'h3FF8 | 16'(c));
            chk(16'(osc_mode), 16'(c));
            chk({13'h0000, osc_pin_out_oe, osc_pin_out_gpio,
                osc_pin_in_gpio}, 16'(pin_tab[c]));
        end
    endtask
    // Divided clock out in internal and RC clock-out modes
    task automatic t_divided_out();
        for (int c = 5; c <= 7; c += 2) begin
            w(14'h2007, 16'h3FF8 | 16'(c));
            pulses(2);
            out_rises = 0;
            pulses(32);
            chk(16'(out_rises >= 7 && out_rises <= 9),
                16'h0001);
        end
    endtask
    // Crystal start-up count and external clock bypass
    task automatic t_startup();
        w(14'h2007, 16'h3FFA);
        @(posedge clk);
        sleep_active <= 1'b1;
        @(posedge clk);
        sleep_active <= 1'b0;
        pulses(1023);
        step(6);
        chk(16'(startup_release), 16'h0000);
        pulses(1);
        step(6);
        chk(16'(startup_release), 16'h0001);
        w(14'h2007, 16'h3FFB);
        @(posedge clk);
        sleep_active <= 1'b1;
        @(posedge clk);
        sleep_active <= 1'b0;
        step(2);
        chk(16'(startup_release), 16'h0001);
    endtask
    // Brown-out field codes against sleep
    task automatic t_brownout();
        for (int c = 0; c < 4; c++) begin
            for (int s = 0; s < 2; s++) begin
                w(14'h2007, 16'h3CFF | 16'(c << 8));
                @(posedge clk);
                sleep_active <= s[0];
                step(2);
                chk(16'(brownout_active),
                    16'(c >= 2 && (c % 2 == 1 || s == 0)));
                chk(16'(powerup_timer_on), 16'h0000);
            end
        end
        @(posedge clk);
        sleep_active <= 1'b0;
    endtask
    // Reset pin function and oscillator stop while held
    task automatic t_reset_pin();
        int n;
        @(posedge clk);
        master_reset_n <= 1'b0;
        w(14'h2007, 16'h3FFF);
        for (n = 0; n < 40 && internal_reset_n !== 1'b0; n++) step(1);
        chk(16'(internal_reset_n), 16'h0000);
        if (n == 40) report_and_stop();
        chk(16'(internal_osc_off), 16'h0001);
        w(14'h2007, 16'h3FFC);
        chk(16'(internal_osc_off), 16'h0001);
        w(14'h2007, 16'h3FFA);
        chk(16'(internal_osc_off), 16'h0000);
        w(14'h2007, 16'h3FDC);
        chk({internal_reset_n, reset_pin_function}, 16'h0002);
        @(posedge clk);
        master_reset_n <= 1'b1;
        // Pin released: oscillator runs again, reset inactive
        w(14'h2007, 16'h3FFC);
        step(4);
        chk({internal_reset_n, internal_osc_off}, 16'h0002);
    endtask
    // Out of program mode: writes refused, settings hold, no read-out
    task automatic t_hold();
        cfg_prog_model_i.set_mode(1'b0);
        w(14'h2007, 16'h3FF8);
        step(2);
        chk(16'(osc_mode), 16'h0004);
        chk(16'(mem_read_allow), 16'h0000);
    endtask
    // Regulator capacitor pin codes on both variants
    task automatic t_cap();
        w(14'h2008, 16'h0000);
        rd(14'h2008, 16'hFFCF, 1'b1);
        for (int lv = 0; lv < 2; lv++) begin
            @(posedge clk);
            low_voltage_part <= lv[0];
            for (int c = 0; c < 4; c++) begin
                w(14'h2008, 16'hFFCF | 16'(c << 4));
                chk(16'(regulator_cap_pin_sel), 16'(c));
                chk(16'(regulator_cap_pin),
                    (lv == 1 || c == 3) ? 16'h0000 : 16'(1 << c));
            end
        end
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        low_voltage_part = 1'b0;
        master_reset_n = 1'b1;
        osc_pin_in = 1'b0;
        sleep_active = 1'b0;
        mismatches = 0;
        checks = 0;
        erases = 0;
        out_rises = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_access();
        t_word_one();
        t_osc_modes();
        t_divided_out();
        t_startup();
        t_brownout();
        t_reset_pin();
        t_cap();
        t_hold();
        report_and_stop();
    end
endmodule
